// ===== rtl/dcf_channel.sv
`timescale 1ns/1ps
`include "dcf_consts.svh"

// Contract
// - fall-through flags at empty and full counts
// - almost-empty low up to offset, plus one in fall-through
// - almost-full low from depth minus offset, depth+1 in fall-through
// - fall-through half-full low from half plus two
// - straps 0,1 give fall-through, triple/double buffering
// - straps 1,0 give standard, double buffering
// - straps 0,0 give standard, single buffering
// - first-load picks partial flag timing, except 1,1
// - channel reset zeroes both pointers
// - reset sets half-full, almost-full high, almost-empty low
// - reset full high, empty per mode
// - reset clears output data, loads default offsets
// - write data captured on rising clock edge
// - correct with read and write coincident
// - eighteen bit write data word
// - sync partial flags update on own side
// - async partial flags follow count immediately
// - standard empty at zero, full at depth
// - writes ignored while full
module dcf_channel
    import dcf_pkg::*;
#(
    parameter int DEPTH = 256
)(
    // clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst,
    // channel reset and straps
    input  wire logic                     i_channel_reset_n,
    input  wire logic                     i_first_load_sel,
    input  wire logic                     i_read_expand_in,
    input  wire logic                     i_write_expand_in,
    // write side
    input  wire logic                     i_write_en,
    input  wire logic [`DCF_DATA_W-1:0]   i_write_data_in,
    // read side
    input  wire logic                     i_read_en,
    output logic      [`DCF_DATA_W-1:0]   o_read_data,
    // flags, active low except empty and full, which go high at empty and full in fall-through
    output logic                          o_empty_flag_n,
    output logic                          o_full_flag_n,
    output logic                          o_half_full_n,
    output logic                          o_almost_empty_n,
    output logic                          o_almost_full_n,
    // wishbone slave
    input  wire logic                     i_wb_cyc,
    input  wire logic                     i_wb_stb,
    input  wire logic                     i_wb_we,
    input  wire logic [7:0]               i_wb_adr,
    input  wire logic [3:0]               i_wb_sel,
    input  wire logic [31:0]              i_wb_dat,
    output logic      [31:0]              o_wb_dat,
    output logic                          o_wb_ack
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [`DCF_CNT_W-1:0] DEPTH_C  = `DCF_CNT_W'(DEPTH);
    localparam logic [`DCF_CNT_W-1:0] HF_STD   = `DCF_CNT_W'(DEPTH/2 + 1);
    localparam logic [`DCF_CNT_W-1:0] HF_FALL_THROUGH_MODE  = `DCF_CNT_W'(DEPTH/2 + 2);
    localparam logic [`DCF_OFF_W-1:0] OFF_DEF  =
        (DEPTH == 256) ? `DCF_OFF_DEF_256 :
        (DEPTH == 512) ? `DCF_OFF_DEF_512 : `DCF_OFF_DEF_BIG;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [`DCF_DATA_W-1:0] mem [DEPTH];
    logic [AW-1:0]          wr_ptr;
    logic [AW-1:0]          rd_ptr;
    logic [`DCF_CNT_W-1:0]  mem_cnt;
    logic                   out_valid;
    dcf_mode_t              mode;
    logic                   sync_pf;
    dcf_buf_t               ef_buf;
    dcf_buf_t               ff_buf;
    logic [`DCF_OFF_W-1:0]  empty_off;
    logic [`DCF_OFF_W-1:0]  full_off;

    logic                   rst_any;
    logic                   fall_through_mode;
    logic                   accept;
    logic                   pop;
    logic                   next_out_valid;
    logic [`DCF_CNT_W-1:0]  next_mem_cnt;
    logic [`DCF_CNT_W-1:0]  total;
    logic [`DCF_CNT_W-1:0]  next_total;
    logic [`DCF_CNT_W-1:0]  pf_cnt;
    logic [`DCF_CNT_W-1:0]  cap;
    logic [`DCF_CNT_W-1:0]  paf_thr;
    logic [`DCF_CNT_W-1:0]  pae_thr;
    logic                   ef_raw;
    logic                   ff_raw;
    logic                   dec_fall_through_mode;
    logic                   dec_sync;
    dcf_buf_t               dec_ef_buf;
    dcf_buf_t               dec_ff_buf;

    assign rst_any = i_rst | ~i_channel_reset_n;
    assign fall_through_mode    = (mode == DCF_MODE_FALL_THROUGH_MODE);

    ////////////////////////////////////////////////////////////////////////
    // strap decode
    always_comb begin
        dec_fall_through_mode   = 1'b0;
        dec_ef_buf = DCF_BUF_SINGLE;
        dec_ff_buf = DCF_BUF_SINGLE;
        case ({i_read_expand_in, i_write_expand_in})
            2'b01: begin
                dec_fall_through_mode   = 1'b1;
                dec_ef_buf = DCF_BUF_TRIPLE;
                dec_ff_buf = DCF_BUF_DOUBLE;
            end
            2'b10: begin
                dec_ef_buf = DCF_BUF_DOUBLE;
                dec_ff_buf = DCF_BUF_DOUBLE;
            end
            default: begin
                dec_fall_through_mode   = 1'b0;
            end
        endcase
        // both expansion pins high forces async partial flags
        dec_sync = i_first_load_sel &
                   ~(i_read_expand_in & i_write_expand_in);
    end

    // straps are followed for as long as the channel reset is held
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode    <= DCF_MODE_STD;
            sync_pf <= 1'b0;
            ef_buf  <= DCF_BUF_SINGLE;
            ff_buf  <= DCF_BUF_SINGLE;
        end else if (!i_channel_reset_n) begin
            mode    <= dec_fall_through_mode ? DCF_MODE_FALL_THROUGH_MODE : DCF_MODE_STD;
            sync_pf <= dec_sync;
            ef_buf  <= dec_ef_buf;
            ff_buf  <= dec_ff_buf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data path; one clock, so coincident read and write just work
    always_comb begin
        accept = i_write_en & (mem_cnt != DEPTH_C);
        if (fall_through_mode) begin
            pop = (mem_cnt != '0) & (~out_valid | i_read_en);
            next_out_valid = pop | (out_valid & ~i_read_en);
        end else begin
            pop = i_read_en & (mem_cnt != '0);
            next_out_valid = 1'b0;
        end
        next_mem_cnt = mem_cnt + `DCF_CNT_W'(accept)
                     - `DCF_CNT_W'(pop);
        total      = mem_cnt + `DCF_CNT_W'(out_valid);
        next_total = next_mem_cnt + `DCF_CNT_W'(next_out_valid);
    end

    // storage has no reset; the pointers alone define contents
    always_ff @(posedge i_core_clk) begin
        if (accept) begin
            mem[wr_ptr] <= i_write_data_in;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            mem_cnt   <= '0;
            out_valid <= 1'b0;
        end else begin
            if (accept) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            mem_cnt   <= next_mem_cnt;
            out_valid <= next_out_valid;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            o_read_data <= '0;
        end else if (pop) begin
            o_read_data <= mem[rd_ptr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // thresholds; output register adds a word in fall-through
    always_comb begin
        cap     = fall_through_mode ? DEPTH_C + 1'b1 : DEPTH_C;
        paf_thr = cap - `DCF_CNT_W'(full_off);
        pae_thr = `DCF_CNT_W'(empty_off) +
                  `DCF_CNT_W'(fall_through_mode);
        // async follows the count at once, sync waits a clock
        pf_cnt  = sync_pf ? total : next_total;
        ef_raw  = fall_through_mode ? (total == '0) : (total != '0);
        ff_raw  = fall_through_mode ? (total == cap) : (total != cap);
    end

    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            o_half_full_n    <= 1'b1;
            o_almost_full_n  <= 1'b1;
            o_almost_empty_n <= 1'b0;
        end else begin
            o_half_full_n    <= fall_through_mode ? (pf_cnt < HF_FALL_THROUGH_MODE)
                                     : (pf_cnt < HF_STD);
            o_almost_full_n  <= (pf_cnt < paf_thr);
            o_almost_empty_n <= (pf_cnt > pae_thr);
        end
    end

    // empty resets low in standard, high in fall-through
    dcf_flag_buf u_ef_buf (
        .i_core_clk (i_core_clk),
        .i_rst      (rst_any),
        .i_rst_val  (dec_fall_through_mode),
        .i_depth    (ef_buf),
        .i_flag     (ef_raw),
        .o_flag     (o_empty_flag_n)
    );

    dcf_flag_buf u_ff_buf (
        .i_core_clk (i_core_clk),
        .i_rst      (rst_any),
        .i_rst_val  (1'b1),
        .i_depth    (ff_buf),
        .i_flag     (ff_raw),
        .o_flag     (o_full_flag_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // offset registers and wishbone slave, ack one clock after request
    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            empty_off <= OFF_DEF;
            full_off  <= OFF_DEF;
        end else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack) begin
            if (i_wb_adr == `DCF_REG_EMPTY_OFF) begin
                if (i_wb_sel[0]) empty_off[7:0]  <= i_wb_dat[7:0];
                if (i_wb_sel[1]) empty_off[11:8] <= i_wb_dat[11:8];
            end else if (i_wb_adr == `DCF_REG_FULL_OFF) begin
                if (i_wb_sel[0]) full_off[7:0]   <= i_wb_dat[7:0];
                if (i_wb_sel[1]) full_off[11:8]  <= i_wb_dat[11:8];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
        end else begin
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
            o_wb_dat <= `DCF_UNMAPPED_RD;
            if (i_wb_adr == `DCF_REG_EMPTY_OFF) begin
                o_wb_dat[`DCF_OFF_W-1:0] <= empty_off;
            end else if (i_wb_adr == `DCF_REG_FULL_OFF) begin
                o_wb_dat[`DCF_OFF_W-1:0] <= full_off;
            end else if (i_wb_adr == `DCF_REG_STATUS) begin
                o_wb_dat[`DCF_ST_CNT_MSB:0]  <= total;
                o_wb_dat[`DCF_ST_EF_BIT]     <= o_empty_flag_n;
                o_wb_dat[`DCF_ST_FF_BIT]     <= o_full_flag_n;
                o_wb_dat[`DCF_ST_HF_BIT]     <= o_half_full_n;
                o_wb_dat[`DCF_ST_PAE_BIT]    <= o_almost_empty_n;
                o_wb_dat[`DCF_ST_PAF_BIT]    <= o_almost_full_n;
            end else if (i_wb_adr == `DCF_REG_CONFIG) begin
                o_wb_dat[`DCF_CF_FALL_THROUGH_MODE_BIT]   <= fall_through_mode;
                o_wb_dat[`DCF_CF_SYNC_BIT]   <= sync_pf;
                o_wb_dat[`DCF_CF_EFBUF_LSB+:2] <= ef_buf;
                o_wb_dat[`DCF_CF_FFBUF_LSB+:2] <= ff_buf;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_strap_fall_through_mode;
        !i_channel_reset_n && !i_read_expand_in && i_write_expand_in
        ##1 i_channel_reset_n;
    endsequence

    sequence s_strap_both;
        !i_channel_reset_n && i_read_expand_in && i_write_expand_in
        ##1 i_channel_reset_n;
    endsequence

    property p_cfg_fall_through_mode;
        s_strap_fall_through_mode |-> fall_through_mode && ef_buf == DCF_BUF_TRIPLE
                         && ff_buf == DCF_BUF_DOUBLE;
    endproperty
    a_cfg_fall_through_mode: assert property (p_cfg_fall_through_mode)
        else $error("fall-through strap decode wrong");

    property p_cfg_both;
        s_strap_both |-> !fall_through_mode && !sync_pf && ef_buf == DCF_BUF_SINGLE;
    endproperty
    a_cfg_both: assert property (p_cfg_both)
        else $error("both expansion straps decode wrong");

    property p_rst_ptr;
        !i_channel_reset_n |=> wr_ptr == '0 && rd_ptr == '0
                               && mem_cnt == '0;
    endproperty
    a_rst_ptr: assert property (p_rst_ptr)
        else $error("pointers not cleared by channel reset");

    property p_rst_flags;
        !i_channel_reset_n |=> o_half_full_n && o_almost_full_n
                               && !o_almost_empty_n && o_full_flag_n;
    endproperty
    a_rst_flags: assert property (p_rst_flags)
        else $error("flags wrong during reset");

    property p_rst_data;
        !i_channel_reset_n |=> o_read_data == '0 && full_off == OFF_DEF;
    endproperty
    a_rst_data: assert property (p_rst_data)
        else $error("reset did not clear data or offsets");

    property p_no_ovf;
        mem_cnt == DEPTH_C && !pop && i_channel_reset_n
        |=> mem_cnt == DEPTH_C && $stable(wr_ptr);
    endproperty
    a_no_ovf: assert property (p_no_ovf)
        else $error("write taken while full");

    property p_capture;
        accept && i_channel_reset_n
        |=> mem[$past(wr_ptr)] == $past(i_write_data_in);
    endproperty
    a_capture: assert property (p_capture)
        else $error("write word not captured");

    property p_fall_through_mode_empty;
        (fall_through_mode && total == '0 && i_channel_reset_n) [*4]
        |-> o_empty_flag_n && !o_almost_empty_n && o_half_full_n;
    endproperty
    a_fall_through_mode_empty: assert property (p_fall_through_mode_empty)
        else $error("fall-through empty flags wrong");

    property p_std_full;
        (!fall_through_mode && total == DEPTH_C && i_channel_reset_n) [*3]
        |-> !o_full_flag_n && !o_half_full_n;
    endproperty
    a_std_full: assert property (p_std_full)
        else $error("standard full flags wrong");

    property p_hf_fall_through_mode;
        (fall_through_mode && total >= HF_FALL_THROUGH_MODE && i_channel_reset_n) [*3]
        |-> !o_half_full_n;
    endproperty
    a_hf_fall_through_mode: assert property (p_hf_fall_through_mode)
        else $error("fall-through half-full wrong");

    property p_paf;
        (total >= paf_thr && $stable(full_off) && i_channel_reset_n) [*3]
        |-> !o_almost_full_n;
    endproperty
    a_paf: assert property (p_paf)
        else $error("almost-full threshold wrong");

    property p_pae;
        (total > pae_thr && $stable(empty_off) && i_channel_reset_n) [*3]
        |-> o_almost_empty_n;
    endproperty
    a_pae: assert property (p_pae)
        else $error("almost-empty threshold wrong");

endmodule

// ===== rtl/dcf_consts.svh
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define DCF_REG_EMPTY_OFF   8'h00
`define DCF_REG_FULL_OFF    8'h04
`define DCF_REG_STATUS      8'h08
`define DCF_REG_CONFIG      8'h0C

////////////////////////////////////////////////////////////////////////////
// status field positions
`define DCF_ST_CNT_MSB      12
`define DCF_ST_EF_BIT       16
`define DCF_ST_FF_BIT       17
`define DCF_ST_HF_BIT       18
`define DCF_ST_PAE_BIT      19
`define DCF_ST_PAF_BIT      20

////////////////////////////////////////////////////////////////////////////
// config field positions
`define DCF_CF_FALL_THROUGH_MODE_BIT     0
`define DCF_CF_SYNC_BIT     1
`define DCF_CF_EFBUF_LSB    2
`define DCF_CF_FFBUF_LSB    4

////////////////////////////////////////////////////////////////////////////
// offset register width and reset defaults per depth
`define DCF_OFF_W           12
`define DCF_OFF_DEF_256     12'h01F
`define DCF_OFF_DEF_512     12'h03F
`define DCF_OFF_DEF_BIG     12'h07F

////////////////////////////////////////////////////////////////////////////
// data path
`define DCF_DATA_W          18
`define DCF_CNT_W           13
`define DCF_UNMAPPED_RD     32'h0000_0000

`endif

// ===== rtl/dcf_pkg.sv
package dcf_pkg;

    // timing mode latched at channel reset
    typedef enum logic [0:0] {
        DCF_MODE_STD  = 1'b0,
        DCF_MODE_FALL_THROUGH_MODE = 1'b1
    } dcf_mode_t;

    // extra flag register stages beyond the output flop
    typedef enum logic [1:0] {
        DCF_BUF_SINGLE = 2'b00,
        DCF_BUF_DOUBLE = 2'b01,
        DCF_BUF_TRIPLE = 2'b10
    } dcf_buf_t;

endpackage

// ===== rtl/dcf_flag_buf.sv
`timescale 1ns/1ps

module dcf_flag_buf
    import dcf_pkg::*;
(
    // clock and reset
    input  wire logic     i_core_clk,
    input  wire logic     i_rst,
    input  wire logic     i_rst_val,
    // flag path
    input  wire dcf_buf_t i_depth,
    input  wire logic     i_flag,
    output logic          o_flag
);

    logic [1:0] stage;

    ////////////////////////////////////////////////////////////////////////
    // extra stages trade latency for metastability margin
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_stage
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    stage[g] <= i_rst_val;
                end else if (g == 0) begin
                    stage[g] <= i_flag;
                end else begin
                    stage[g] <= stage[g-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_flag <= i_rst_val;
        end else begin
            case (i_depth)
                DCF_BUF_SINGLE: o_flag <= i_flag;
                DCF_BUF_DOUBLE: o_flag <= stage[0];
                default:        o_flag <= stage[1];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_double_lat;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_depth == DCF_BUF_DOUBLE) [*3] |-> o_flag == $past(i_flag, 2);
    endproperty
    a_double_lat: assert property (p_double_lat)
        else $error("double buffered flag latency wrong");

endmodule

// ===== dv/dcf_far_side.sv
`timescale 1ns/1ps
`include "dcf_consts.svh"

// writer and reader logic facing the channel, one clock
module dcf_far_side (
    // clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    // requests from the bench
    input  wire logic                   i_wr_req,
    input  wire logic                   i_rd_req,
    // toward the channel
    output logic                        o_write_en,
    output logic [`DCF_DATA_W-1:0]      o_write_data_in,
    output logic                        o_read_en
);
    logic        seen_rst;
    logic [15:0] seq;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            seen_rst        <= 1'b1;
            seq             <= 16'h0000;
            o_write_en      <= 1'b0;
            o_read_en       <= 1'b0;
            o_write_data_in <= 18'h3FFFF;
        end else begin
            // no write until a reset has been seen
            o_write_en <= i_wr_req && (seen_rst === 1'b1);
            o_read_en  <= i_rd_req;
            if (i_wr_req) begin
                o_write_data_in <= {2'b10, seq ^ 16'hA5A5};
                seq             <= seq + 16'h0001;
            end else begin
                // idle bus flips so a stale word never looks valid
                o_write_data_in <= ~o_write_data_in;
            end
        end
    end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "dcf_consts.svh"

module tb_top;
    typedef struct packed {logic [2:0] strap; logic [7:0] cfg;} dcf_row_t;
    localparam int DEPTH = 256;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ch_rst_n = 1'b1;
    logic [2:0]  straps = 3'b000;
    logic        wr_req = 1'b0;
    logic        rd_req = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wd = 32'h0;
    logic [31:0] wb_rd;
    logic        wb_ack;
    logic        wen;
    logic        ren;
    logic [17:0] wdat;
    logic [17:0] rdat;
    logic [4:0]  flags;
    logic [31:0] rd;
    int          err_count = 0;
    int          num_checks = 0;
    int          nwr = 0;
    int          cycles = 0;
    int          s0;
    // strap combination against config register and reset empty level
    dcf_row_t    rows [8] = '{'{3'b000, 8'h00}, '{3'b001, 8'h19},
                              '{3'b010, 8'h14}, '{3'b011, 8'h00},
                              '{3'b100, 8'h02}, '{3'b101, 8'h1B},
                              '{3'b110, 8'h16}, '{3'b111, 8'h00}};

    always #25 clk = ~clk;

    dcf_far_side dcf_far_side_i (
        .i_core_clk(clk), .i_rst(rst), .i_wr_req(wr_req), .i_rd_req(rd_req),
        .o_write_en(wen), .o_write_data_in(wdat), .o_read_en(ren));

    dcf_channel #(.DEPTH(DEPTH)) dcf_channel_i (
        .i_core_clk(clk), .i_rst(rst), .i_channel_reset_n(ch_rst_n),
        .i_first_load_sel(straps[2]), .i_read_expand_in(straps[1]),
        .i_write_expand_in(straps[0]), .i_write_en(wen),
        .i_write_data_in(wdat), .i_read_en(ren), .o_read_data(rdat),
        .o_empty_flag_n(flags[4]), .o_full_flag_n(flags[3]),
        .o_half_full_n(flags[2]), .o_almost_empty_n(flags[1]),
        .o_almost_full_n(flags[0]), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF),
        .i_wb_dat(wb_wd), .o_wb_dat(wb_rd), .o_wb_ack(wb_ack));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        // ceiling well above the two fills plus register traffic
        if (cycles == 30000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    function automatic logic [17:0] word(input int k);
        return {2'b10, 16'(k) ^ 16'hA5A5};
    endfunction

    function automatic logic [4:0] exp_flags(input logic fw, input int c,
                                             input int n, input int m);
        int cap;
        cap = fw ? DEPTH + 1 : DEPTH;
        return {fw ? c == 0 : c != 0, fw ? c == cap : c != cap,
                ~(c >= DEPTH / 2 + 1 + fw), ~(c <= n + fw), ~(c >= cap - m)};
    endfunction

    // wishbone classic single cycle, held until ack is seen
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rv);
        int t;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wd <= wd;
        t = 0;
        do begin
            @(posedge clk);
            #1;
            t++;
        end while (wb_ack !== 1'b1 && t < 20);
        check("wb ack", 32'h1, {31'h0, wb_ack});
        rv = wb_rd;
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic chan_reset(input logic [2:0] s, input logic ef);
        @(posedge clk);
        ch_rst_n <= 1'b0;
        straps <= s;
        repeat (2) @(posedge clk);
        #1;
        check("reset flags", {27'h0, ef, 4'b1101}, {27'h0, flags});
        check("reset data", 32'h0, {14'h0, rdat});
        @(posedge clk);
        ch_rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic req(input logic w);
        @(posedge clk);
        if (w) wr_req <= 1'b1;
        else rd_req <= 1'b1;
        @(posedge clk);
        wr_req <= 1'b0;
        rd_req <= 1'b0;
        if (w) nwr++;
    endtask

    // one word at a time past capacity, flags after settling
    task automatic fill(input logic fw);
        int cap;
        cap = fw ? DEPTH + 1 : DEPTH;
        for (int k = 1; k <= cap + 2; k++) begin
            req(1'b1);
            repeat (6) @(posedge clk);
            #1;
            check("flags", {27'h0, exp_flags(fw, k > cap ? cap : k, 31, 31)},
                  {27'h0, flags});
        end
        wb(1'b0, `DCF_REG_STATUS, 32'h0, rd);
        check("count", 32'(cap), {19'h0, rd[`DCF_ST_CNT_MSB:0]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            chan_reset(rows[r].strap, rows[r].cfg[0]);
            wb(1'b0, `DCF_REG_CONFIG, 32'h0, rd);
            check("config", {24'h0, rows[r].cfg}, rd);
            wb(1'b0, `DCF_REG_EMPTY_OFF, 32'h0, rd);
            check("empty offset", 32'h1F, rd);
            wb(1'b0, `DCF_REG_FULL_OFF, 32'h0, rd);
            check("full offset", 32'h1F, rd);
        end
        chan_reset(3'b001, 1'b1);
        s0 = nwr;
        fill(1'b1);
        check("head word", {14'h0, word(s0)}, {14'h0, rdat});
        chan_reset(3'b000, 1'b0);
        s0 = nwr;
        fill(1'b0);
        req(1'b0);
        repeat (4) @(posedge clk);
        check("first out", {14'h0, word(s0)}, {14'h0, rdat});
        chan_reset(3'b000, 1'b0);
        wb(1'b0, `DCF_REG_STATUS, 32'h0, rd);
        check("count", 32'h0, {19'h0, rd[`DCF_ST_CNT_MSB:0]});
        req(1'b1);
        repeat (4) @(posedge clk);
        req(1'b0);
        repeat (4) @(posedge clk);
        check("after reset", {14'h0, word(nwr - 1)}, {14'h0, rdat});
        // unmapped place reads zero and ignores writes
        wb(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
        wb(1'b0, 8'h40, 32'h0, rd);
        check("unmapped", `DCF_UNMAPPED_RD, rd);
        // partial flag and empty flag latency at the first word
        for (int i = 0; i < 2; i++) begin
            chan_reset(i ? 3'b110 : 3'b000, 1'b0);
            wb(1'b1, `DCF_REG_EMPTY_OFF, 32'h0, rd);
            req(1'b1);
            @(posedge clk);
            #1;
            check("pae at store", {31'h0, ~i[0]}, {31'h0, flags[1]});
            check("ef at store", 32'h0, {31'h0, flags[4]});
            @(posedge clk);
            #1;
            check("pae next", 32'h1, {31'h0, flags[1]});
            check("ef next", {31'h0, ~i[0]}, {31'h0, flags[4]});
        end
        report_and_stop();
    end
endmodule
